// *** rtl/mal_top.sv ***
`timescale 1ns/1ps
module mal_top #(
  parameter int          NPORT        = mal_pkg::NPORT_DEF,
  parameter logic [35:0] AGE_HALF_CYC = mal_pkg::AGE_HALF_CYC
)(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              direct_map_i,
  input  wire logic              aging_en_i,
  input  wire logic              stp_en_i,
  input  wire logic [NPORT-1:0]  port_dis_i,
  input  wire logic [NPORT-1:0]  port_sec_i,
  input  mal_pkg::mal_stp_t      stp_state_i [NPORT],
  input  wire logic              req_vld_i,
  input  mal_pkg::mal_req_t      req_i,
  output logic                   req_ready_o,
  input  wire logic              stat_vld_i,
  input  mal_pkg::mal_stat_t     stat_i,
  output logic                   stat_ready_o,
  output mal_pkg::mal_res_t      res_o,
  output logic                   age_busy_o
);
  import mal_pkg::*;

  if (NPORT < 2 || NPORT > (1 << PORT_W) || AGE_HALF_CYC == 36'h0) begin : g_chk
    $error("mal_top parameters out of range");
  end

  typedef enum logic {MAL_IDLE, MAL_LOOK} mal_st_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  mal_st_t               st_q, st_d;            // Engine phase
  logic                  rdy_q, rdy_d;          // Ready for next request
  mal_req_t              req_q, req_d;          // Frame held for lookup
  mal_res_t              res_q, res_d;          // Registered result
  logic [35:0]           div_q, div_d;          // Half-period divider
  logic                  pend_q, pend_d;        // Sweep requested
  logic [SWEEP_W-1:0]    sw_q, sw_d;            // Sweep position
  mal_ent_t              tbl_q [TBL_DEPTH];     // Indexed table
  logic                  tw_en;                 // Table write
  logic [TBL_IDX_W-1:0]  tw_idx;
  mal_ent_t              tw_ent;
  logic                  cw_en;                 // Store write
  logic [CAM_IDX_W-1:0]  cw_idx;
  mal_ent_t              cw_ent;

  // ----------------------------------------
  // Keys and index units
  // ----------------------------------------
  logic [MAC_W-1:0]      sa_key;                // Learn or static key
  logic [TBL_IDX_W-1:0]  da_idx, sa_idx;
  logic                  tick;                  // Half-period pulse
  logic                  cam_hit_a, cam_hit_b, cam_free;
  logic [CAM_IDX_W-1:0]  cam_idx_b, cam_free_idx;
  mal_ent_t              cam_ent_a, cam_ent_b, cam_rd;

  assign sa_key = (st_q == MAL_LOOK) ? {req_q.sa[MAC_W-1:1], 1'b0}
                                     : {stat_i.mac[MAC_W-1:1], 1'b0};
  assign tick   = aging_en_i && (div_q == AGE_HALF_CYC - 36'h1);

  mal_hash u_hash_da (
    .mac_i    (req_q.da),
    .direct_i (direct_map_i),
    .idx_o    (da_idx)
  );

  mal_hash u_hash_sa (
    .mac_i    (sa_key),
    .direct_i (direct_map_i),
    .idx_o    (sa_idx)
  );

  mal_cam u_cam (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .key_a_i    (req_q.da),
    .key_b_i    (sa_key),
    .rd_idx_i   (sw_q[CAM_IDX_W-1:0]),
    .wr_en_i    (cw_en),
    .wr_idx_i   (cw_idx),
    .wr_ent_i   (cw_ent),
    .hit_a_o    (cam_hit_a),
    .ent_a_o    (cam_ent_a),
    .hit_b_o    (cam_hit_b),
    .idx_b_o    (cam_idx_b),
    .ent_b_o    (cam_ent_b),
    .rd_ent_o   (cam_rd),
    .free_o     (cam_free),
    .free_idx_o (cam_free_idx)
  );

  // ----------------------------------------
  // Aging divider
  // ----------------------------------------
  // periodic sweep request; a new tick wins over sweep completion
  always_comb begin
    div_d  = aging_en_i ? (tick ? 36'h0 : div_q + 36'h1) : 36'h0;
    pend_d = pend_q;
    if (st_q == MAL_IDLE && !req_vld_i && !stat_vld_i && pend_q &&
        sw_q == SWEEP_W'(TBL_DEPTH + CAM_DEPTH - 1)) begin
      pend_d = 1'b0;
    end
    if (tick) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= 36'h0;
      pend_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------
  // Lookup, learning and sweep engine
  // ----------------------------------------
  always_comb begin
    mal_ent_t          da_t, sa_t, fent, sw_e;
    logic              da_hit, sa_hit, found, moved, viol, err, pv, learn;
    logic              bl_st, fw_st;
    mal_stp_t          pst;
    logic [PORT_W-1:0] dport;
    da_t   = tbl_q[da_idx];
    sa_t   = tbl_q[sa_idx];
    sw_e   = sw_q < SWEEP_W'(TBL_DEPTH) ? tbl_q[sw_q[TBL_IDX_W-1:0]] : cam_rd;
    da_hit = da_t.vld && (da_t.mac == req_q.da);
    sa_hit = sa_t.vld && (sa_t.mac == sa_key);
    found  = sa_hit || cam_hit_b;
    fent   = sa_hit ? sa_t : cam_ent_b;
    pv     = int'(req_q.src_port) < NPORT;
    pst    = pv ? stp_state_i[req_q.src_port] : MAL_STP_DISABLED;
    bl_st  = stp_en_i && (pst == MAL_STP_BLOCK_LISTEN || pst == MAL_STP_LEARNING);
    fw_st  = stp_en_i && (pst == MAL_STP_FORWARDING);
    err    = req_q.rx_err || req_q.buf_full;
    moved  = found && (fent.port != req_q.src_port);
    viol   = moved && pv && port_sec_i[req_q.src_port];
    // three learn sources, clean frames only
    learn  = !err && !viol && pv && !port_dis_i[req_q.src_port] &&
             !(req_q.src_kind == MAL_SRC_CONV && req_q.own_msg) &&
             !(stp_en_i && pst == MAL_STP_BLOCK_LISTEN);
    dport  = da_hit ? da_t.port : cam_ent_a.port;
    st_d   = st_q;
    req_d  = req_q;
    res_d  = RES_RST;
    sw_d   = sw_q;
    tw_en  = 1'b0;
    tw_idx = sa_idx;
    tw_ent = ENT_RST;
    cw_en  = 1'b0;
    cw_idx = cam_idx_b;
    cw_ent = ENT_RST;
    case (st_q)
      MAL_IDLE: begin
        if (req_vld_i) begin
          // New frame has priority over static install and sweep
          req_d = req_i;
          st_d  = MAL_LOOK;
        end else if (stat_vld_i) begin
          // Static install: same address in place, else empty slot, else store
          tw_ent = '{vld: 1'b1, stat: 1'b1, age: 1'b0, port: stat_i.port, mac: sa_key};
          cw_ent = tw_ent;
          if (cam_hit_b) begin
            cw_en = 1'b1;
          end else if (sa_hit || !sa_t.vld) begin
            tw_en = 1'b1;
          end else if (cam_free) begin
            cw_en  = 1'b1;
            cw_idx = cam_free_idx;
          end
        end else if (pend_q) begin
          tw_ent = sw_e;
          if (sw_e.vld && !sw_e.stat) begin
            tw_ent = sw_e.age ? ENT_RST : mal_ent_t'{vld: 1'b1, stat: 1'b0, age: 1'b1,
                                                    port: sw_e.port, mac: sw_e.mac};
          end
          cw_ent = tw_ent;
          tw_idx = sw_q[TBL_IDX_W-1:0];
          cw_idx = sw_q[CAM_IDX_W-1:0];
          tw_en  = sw_q < SWEEP_W'(TBL_DEPTH);
          cw_en  = !tw_en;
          sw_d   = (sw_q == SWEEP_W'(TBL_DEPTH + CAM_DEPTH - 1)) ? '0 : sw_q + 1'b1;
        end
      end
      MAL_LOOK: begin
        res_d.vld      = 1'b1;
        res_d.hit      = !req_q.da[0] && (da_hit || cam_hit_a);
        res_d.flood    = !res_d.hit;
        res_d.port     = res_d.hit ? dport : '0;
        res_d.sec_viol = viol;
        res_d.drop     = err || !pv || port_dis_i[req_q.src_port] ||
                         req_q.src_kind == MAL_SRC_CONV;
        if (res_d.hit && dport == req_q.src_port) begin
          res_d.drop = 1'b1;
        end
        if (viol) begin
          res_d.drop = 1'b1;
        end
        if (bl_st) begin
          res_d.to_cpu = req_q.bpdu && !res_d.drop;
          res_d.drop   = 1'b1;
        end
        if (fw_st && req_q.bpdu && !res_d.drop) begin
          res_d.to_cpu = 1'b1;
          res_d.drop   = 1'b1;
        end
        // Learning: refresh in place, new slot, or overflow to store
        tw_ent = '{vld: 1'b1, stat: 1'b0, age: 1'b0, port: req_q.src_port, mac: sa_key};
        cw_ent = tw_ent;
        if (learn && !(found && fent.stat)) begin
          if (sa_hit) begin
            tw_en = 1'b1;
          end else if (cam_hit_b) begin
            cw_en = 1'b1;
          end else if (!sa_t.vld) begin
            tw_en = 1'b1;
          end else if (cam_free) begin
            cw_en  = 1'b1;
            cw_idx = cam_free_idx;
          end
        end
        st_d = MAL_IDLE;
      end
      default: begin
        st_d = MAL_IDLE;
      end
    endcase
    rdy_d = (st_d == MAL_IDLE);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= MAL_IDLE;
      rdy_q <= 1'b0;
      req_q <= '0;
      res_q <= RES_RST;
      sw_q  <= '0;
    end else begin
      st_q  <= st_d;
      rdy_q <= rdy_d;
      req_q <= req_d;
      res_q <= res_d;
      sw_q  <= sw_d;
    end
  end

  // ----------------------------------------
  // Indexed table storage
  // ----------------------------------------
  // reset empties table; flops trade area for single-cycle access
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        tbl_q[i] <= ENT_RST;
      end
    end else if (tw_en) begin
      tbl_q[tw_idx] <= tw_ent;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign req_ready_o  = rdy_q;
  assign stat_ready_o = rdy_q;
  assign res_o        = res_q;
  assign age_busy_o   = pend_q;

endmodule

// *** rtl/mal_pkg.sv ***
// Contract
// - 8K indexed table plus 128-entry associative store
// - Hash DA, check store, forward or flood
// - Colliding source address goes to store
// - Remove unrefreshed dynamic entries after 300 s
// - Hash or direct index chosen by configuration
// - Reset clears all learned table contents
// - Static entries never aged, overwritten, moved
// - Learn only error-free, violation-free frames
// - Unprotected port move rewrites entry's port
// - Secure port move is a security violation
// - Direct mode uses lowest 13 address bits
// - Learn from local, ring, foreign convergence
// - Frames with receive errors not forwarded
// - Drop frame resolved to its own port
// - Drop frames of disabled ports
// - Drop frame when input buffer full
// - Drop violating frame on secure port
// - Blocking/learning: BPDU to CPU, drop rest
// - Forwarding state: BPDU to CPU
package mal_pkg;

  // ----------------------------------------
  // Table geometry
  // ----------------------------------------
  localparam int TBL_DEPTH  = 8192;   // Indexed entries
  localparam int TBL_IDX_W  = 13;     // Index width
  localparam int CAM_DEPTH  = 128;    // Associative entries
  localparam int CAM_IDX_W  = 7;      // Associative index width
  localparam int MAC_W      = 48;     // Address width
  localparam int PORT_W     = 3;      // Port number width
  localparam int NPORT_DEF  = 8;      // Ports served
  localparam int SWEEP_W    = 14;     // Covers both stores

  // ----------------------------------------
  // Aging timing
  // ----------------------------------------
  localparam longint CLK_HZ       = 25_000_000;  // System clock rate
  localparam longint AGE_PERIOD_S = 300;         // Aging period, seconds
  // Two sweeps per period: an entry idle for a whole period is removed
  localparam logic [35:0] AGE_HALF_CYC = 36'((AGE_PERIOD_S * CLK_HZ) / 2);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MAL_SRC_LOCAL,      // Local port frame
    MAL_SRC_RING,       // Frame forwarded over ring
    MAL_SRC_CONV        // Table convergence message
  } mal_src_t;

  typedef enum logic [1:0] {
    MAL_STP_DISABLED,
    MAL_STP_BLOCK_LISTEN,
    MAL_STP_LEARNING,
    MAL_STP_FORWARDING
  } mal_stp_t;

  typedef struct packed {
    logic              vld;   // Entry in use
    logic              stat;  // Installed as static
    logic              age;   // Seen by one sweep unrefreshed
    logic [PORT_W-1:0] port;  // Owning port
    logic [MAC_W-1:0]  mac;   // Stored address
  } mal_ent_t;

  localparam mal_ent_t ENT_RST = '0;  // Empty entry

  typedef struct packed {
    logic [MAC_W-1:0]  da;        // Destination address
    logic [MAC_W-1:0]  sa;        // Source address
    logic [PORT_W-1:0] src_port;  // Receiving port
    mal_src_t          src_kind;  // Where the frame came from
    logic              own_msg;   // Convergence message issued here
    logic              rx_err;    // Any receive error
    logic              buf_full;  // Input buffer was full
    logic              bpdu;      // Bridge protocol data unit
  } mal_req_t;

  typedef struct packed {
    logic              vld;       // One-cycle result strobe
    logic              hit;       // Destination found
    logic              flood;     // Unknown or group destination
    logic [PORT_W-1:0] port;      // Destination port on hit
    logic              drop;      // Filter verdict
    logic              to_cpu;    // Send to processor port
    logic              sec_viol;  // Security violation seen
  } mal_res_t;

  localparam mal_res_t RES_RST = '0;

  typedef struct packed {
    logic [MAC_W-1:0]  mac;   // Static address
    logic [PORT_W-1:0] port;  // Its port
  } mal_stat_t;

endpackage

// *** rtl/mal_hash.sv ***
`timescale 1ns/1ps
module mal_hash (
  input  wire logic [mal_pkg::MAC_W-1:0]     mac_i,
  input  wire logic                          direct_i,
  output logic      [mal_pkg::TBL_IDX_W-1:0] idx_o
);
  import mal_pkg::*;

  // ----------------------------------------
  // Index computation
  // ----------------------------------------
  // Fold all address bits so vendor prefix bits spread the index
  always_comb begin
    if (direct_i) begin
      idx_o = mac_i[TBL_IDX_W-1:0];
    end else begin
      idx_o = mac_i[12:0] ^ mac_i[25:13] ^ mac_i[38:26] ^ {4'h0, mac_i[47:39]};
    end
  end

endmodule

// *** rtl/mal_cam.sv ***
`timescale 1ns/1ps
module mal_cam #(
  parameter int DEPTH = mal_pkg::CAM_DEPTH,
  parameter int IDX_W = mal_pkg::CAM_IDX_W
)(
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [mal_pkg::MAC_W-1:0] key_a_i,
  input  wire logic [mal_pkg::MAC_W-1:0] key_b_i,
  input  wire logic [IDX_W-1:0]          rd_idx_i,
  input  wire logic                      wr_en_i,
  input  wire logic [IDX_W-1:0]          wr_idx_i,
  input  mal_pkg::mal_ent_t              wr_ent_i,
  output logic                           hit_a_o,
  output mal_pkg::mal_ent_t              ent_a_o,
  output logic                           hit_b_o,
  output logic      [IDX_W-1:0]          idx_b_o,
  output mal_pkg::mal_ent_t              ent_b_o,
  output mal_pkg::mal_ent_t              rd_ent_o,
  output logic                           free_o,
  output logic      [IDX_W-1:0]          free_idx_o
);
  import mal_pkg::*;

  mal_ent_t         ent_q [DEPTH];  // Associative storage
  logic [DEPTH-1:0] match_a;        // Per-entry key A match
  logic [DEPTH-1:0] match_b;        // Per-entry key B match

  if (DEPTH > (1 << IDX_W) || DEPTH < 1) begin : g_chk
    $error("mal_cam depth does not fit index width");
  end

  // ----------------------------------------
  // Parallel compare
  // ----------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
    assign match_a[i] = ent_q[i].vld && (ent_q[i].mac == key_a_i);
    assign match_b[i] = ent_q[i].vld && (ent_q[i].mac == key_b_i);
  end

  // ----------------------------------------
  // Encoders
  // ----------------------------------------
  // One address lives in one place only, so lowest match is the match
  always_comb begin
    hit_a_o    = 1'b0;
    ent_a_o    = ENT_RST;
    hit_b_o    = 1'b0;
    idx_b_o    = '0;
    ent_b_o    = ENT_RST;
    free_o     = 1'b0;
    free_idx_o = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (match_a[i]) begin
        hit_a_o = 1'b1;
        ent_a_o = ent_q[i];
      end
      if (match_b[i]) begin
        hit_b_o = 1'b1;
        idx_b_o = IDX_W'(i);
        ent_b_o = ent_q[i];
      end
      if (!ent_q[i].vld) begin
        free_o     = 1'b1;
        free_idx_o = IDX_W'(i);
      end
    end
    rd_ent_o = ent_q[rd_idx_i];
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // reset clears store
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        ent_q[i] <= ENT_RST;
      end
    end else if (wr_en_i) begin
      ent_q[wr_idx_i] <= wr_ent_i;
    end
  end

endmodule

// *** dv/mal_checker.sv ***
`timescale 1ns/1ps
module mal_checker #(
  parameter int          NPORT        = mal_pkg::NPORT_DEF,
  parameter logic [35:0] AGE_HALF_CYC = mal_pkg::AGE_HALF_CYC
)(
  input wire logic             sys_clk_i,
  input wire logic             rst_i,
  input wire logic [NPORT-1:0] port_dis_i,
  input wire logic [NPORT-1:0] port_sec_i,
  input wire logic             req_vld_i,
  input mal_pkg::mal_req_t     req_i,
  input wire logic             req_ready_o,
  input mal_pkg::mal_res_t     res_o
);
  import mal_pkg::*;
  // -----------------------------
  // Helper state
  // -----------------------------
  logic              take;    // Request accepted
  logic [NPORT-1:0]  sec_q;   // Security options, one back
  logic [NPORT-1:0]  sec_qq;  // Two back, in line with result
  logic [PORT_W-1:0] src_q;   // Receiving port, one back
  logic [PORT_W-1:0] src_qq;  // Two back
  assign take = req_vld_i && req_ready_o;
  // Delay line so a verdict meets the settings of its own frame
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_q  <= '0;
      sec_qq <= '0;
      src_q  <= '0;
      src_qq <= '0;
    end else begin
      sec_q  <= port_sec_i;
      sec_qq <= sec_q;
      src_q  <= req_i.src_port;
      src_qq <= src_q;
    end
  end
  // -----------------------------
  // Properties
  // -----------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_RES_LAT: assert property (take |=> !res_o.vld ##1 res_o.vld)
    else $error("result not two cycles after take");
  AST_RES_ONE: assert property (res_o.vld |=> !res_o.vld)
    else $error("result longer than one cycle");
  AST_RES_SRC: assert property (res_o.vld |-> $past(req_vld_i, 2) && $past(req_ready_o, 2))
    else $error("result without request");
  AST_RDY_GAP: assert property (take |=> !req_ready_o)
    else $error("ready stayed high after take");
  AST_HIT_FLD: assert property (res_o.vld |-> !(res_o.hit && res_o.flood))
    else $error("hit and flood together");
  AST_ERR_DROP: assert property (take && req_i.rx_err |-> ##2 res_o.drop)
    else $error("errored frame passed");
  AST_BUF_DROP: assert property (take && req_i.buf_full |-> ##2 res_o.drop)
    else $error("frame from full buffer passed");
  AST_DIS_DROP: assert property (take && port_dis_i[req_i.src_port] |-> ##2 res_o.drop)
    else $error("frame of disabled port passed");
  AST_SEC_DROP: assert property (res_o.vld && res_o.sec_viol && sec_qq[src_qq] |-> res_o.drop)
    else $error("violation on secure port passed");
  AST_OWN_DROP: assert property (res_o.vld && res_o.hit && res_o.port == src_qq |-> res_o.drop)
    else $error("frame sent back to its own port");
  // Main scenarios reached
  cover property (res_o.vld && res_o.hit);
  cover property (res_o.vld && res_o.flood);
  cover property (res_o.vld && res_o.to_cpu);
  cover property (res_o.vld && res_o.sec_viol);
endmodule

bind mal_top mal_checker #(.NPORT(NPORT), .AGE_HALF_CYC(AGE_HALF_CYC)) i_mal_checker (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .port_dis_i(port_dis_i), .port_sec_i(port_sec_i),
  .req_vld_i(req_vld_i), .req_i(req_i), .req_ready_o(req_ready_o), .res_o(res_o));

// *** dv/mal_mac_model.sv ***
`timescale 1ns/1ps
module mal_mac_model (
  input  wire logic        sys_clk_i,
  input  wire logic        req_ready_i,
  input  mal_pkg::mal_res_t res_i,
  output logic             req_vld_o,
  output mal_pkg::mal_req_t req_o
);
  import mal_pkg::*;
  initial begin
    req_vld_o = 1'b0;
    req_o     = '0;
  end
  // -----------------------------
  // One frame, held until taken
  // -----------------------------
  task automatic send(input mal_req_t q, output mal_res_t r);
    int n;
    @(posedge sys_clk_i);
    req_vld_o <= 1'b1;
    req_o     <= q;
    do @(posedge sys_clk_i); while (req_ready_i !== 1'b1);
    req_vld_o <= 1'b0;
    // Inverted so a late sample cannot see the old frame
    req_o     <= ~q;
    r = '0;
    // Result is a one-cycle strobe, bounded wait
    for (n = 0; n < 4 && r.vld !== 1'b1; n++) begin
      @(posedge sys_clk_i);
      #1 r = res_i;
    end
  endtask
endmodule

// *** dv/mal_top_test.sv ***
`timescale 1ns/1ps
module mal_top_test;
  import mal_pkg::*;
  localparam int          NP    = 8;
  localparam logic [35:0] AGE_T = 36'h14;  // Short aging tick
  localparam logic [47:0] A     = 48'h1234_5678_1abc;
  localparam logic [47:0] D     = 48'h0300_0000_0000;  // Never learned
  logic        sys_clk_i, rst_i, dmap, age_en, stp_en;
  logic        req_vld, req_ready, stat_vld, stat_ready, age_busy;
  logic [NP-1:0] port_dis, port_sec;
  mal_stp_t    stp_state [NP];
  mal_req_t    req;
  mal_stat_t   stat;
  mal_res_t    res, r;
  int          failures, checks, i;
  int          cyc = 0;
  logic [47:0] sa;
  logic [2:0]  p, p2;

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  mal_top #(.NPORT(NP), .AGE_HALF_CYC(AGE_T)) i_mal_top (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .direct_map_i(dmap), .aging_en_i(age_en),
    .stp_en_i(stp_en), .port_dis_i(port_dis), .port_sec_i(port_sec), .stp_state_i(stp_state),
    .req_vld_i(req_vld), .req_i(req), .req_ready_o(req_ready), .stat_vld_i(stat_vld),
    .stat_i(stat), .stat_ready_o(stat_ready), .res_o(res), .age_busy_o(age_busy));

  mal_mac_model i_mal_mac_model (
    .sys_clk_i(sys_clk_i), .req_ready_i(req_ready), .res_i(res), .req_vld_o(req_vld),
    .req_o(req));

  // -----------------------------
  // Checking and closing
  // -----------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, run needs about 25400 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end

  // Expected strobe, hit, flood and port
  function automatic logic [5:0] fwd(input logic h, input logic [2:0] pt);
    return {1'b1, h, !h, pt};
  endfunction

  // One frame; f is kind, own message, error, buffer full, bpdu
  task automatic go(input logic [47:0] d, s, input logic [2:0] pt, input logic [5:0] f);
    mal_req_t q;
    q = '{da: d, sa: s, src_port: pt, src_kind: mal_src_t'(f[5:4]), own_msg: f[3],
          rx_err: f[2], buf_full: f[1], bpdu: f[0]};
    i_mal_mac_model.send(q, r);
  endtask

  // Lookup from port pt with a per-port probe source
  task automatic look(input logic [47:0] d, input logic [2:0] pt, input logic h,
                      input logic [2:0] pe);
    go(d, 48'h0a00_0000_0200 | {pt, 1'b0}, pt, 6'h00);
    check("fwd", {r.vld, r.hit, r.flood, h ? r.port : pe}, fwd(h, pe));
    check("drop", r.drop, h && pt == pe);
  endtask

  // Static install, frames idle meanwhile
  task automatic put_stat(input logic [47:0] m, input logic [2:0] pt);
    @(posedge sys_clk_i);
    stat_vld <= 1'b1;
    stat     <= '{mac: m, port: pt};
    do @(posedge sys_clk_i); while (stat_ready !== 1'b1);
    stat_vld <= 1'b0;
    stat     <= '{mac: ~m, port: ~pt};
  endtask

  // -----------------------------
  // Scenarios
  // -----------------------------
  initial begin
    rst_i    = 1'b1;
    dmap     = 1'b0;
    age_en   = 1'b0;
    stp_en   = 1'b0;
    port_dis = '0;
    port_sec = '0;
    stat_vld = 1'b0;
    stat     = '0;
    failures = 0;
    checks   = 0;
    foreach (stp_state[k]) stp_state[k] = MAL_STP_FORWARDING;
    void'($urandom(1317));
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    look(A, 1, 1'b0, 3'd0);
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk_i) dmap <= i[0];
      sa = {16'($urandom), 32'($urandom)};
      p  = 3'($urandom_range(7, 0));
      p2 = p + 3'($urandom_range(7, 1));
      go(D, sa, p, 6'h00);
      look({sa[47:1], 1'b0}, p2, 1'b1, p);
    end
    // same low index bits in direct mode
    @(posedge sys_clk_i) dmap <= 1'b1;
    go(D, A, 2, 6'h00);
    go(D, A ^ 48'h0000_0001_0000, 5, 6'h00);
    look(A, 0, 1'b1, 3'd2);
    look(A ^ 48'h0000_0001_0000, 0, 1'b1, 3'd5);
    look(A, 2, 1'b1, 3'd2);
    @(posedge sys_clk_i) port_dis[4] <= 1'b1;
    for (i = 0; i < 3; i++) begin
      sa = 48'h0400_0000_0010 + 48'(i << 4);
      go(A, sa, (i == 2) ? 3'd4 : 3'd1, (i == 0) ? 6'h04 : (i == 1) ? 6'h02 : 6'h00);
      check("drop", r.drop, 1);
      look(sa, 0, 1'b0, 3'd0);
    end
    // port move, then move onto a secure port
    go(D, 48'h0500_0000_0040, 1, 6'h00);
    go(D, 48'h0500_0000_0040, 6, 6'h00);
    look(48'h0500_0000_0040, 0, 1'b1, 3'd6);
    @(posedge sys_clk_i) port_sec[3] <= 1'b1;
    go(D, 48'h0500_0000_0040, 3, 6'h00);
    check("viol", {r.sec_viol, r.drop}, 2'b11);
    look(48'h0500_0000_0040, 0, 1'b1, 3'd6);
    put_stat(48'h0600_0000_0050, 4);
    go(D, 48'h0600_0000_0050, 6, 6'h00);
    look(48'h0600_0000_0050, 0, 1'b1, 3'd4);
    // local, ring, foreign and own convergence
    for (i = 0; i < 4; i++) begin
      sa = 48'h0700_0000_0060 + 48'(i << 4);
      go(D, sa, 2, {(i == 3) ? 2'd2 : 2'(i), i == 3, 3'b000});
      check("conv", r.drop, i >= 2);
      look(sa, 0, i != 3, 3'd2);
    end
    // every spanning tree state with and without bpdu
    @(posedge sys_clk_i) stp_en <= 1'b1;
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk_i) stp_state[7] <= mal_stp_t'(i);
      go(A, 48'h0a00_0000_0300, 7, 6'h01);
      check("cpu", r.to_cpu, i != 0);
      go(A, 48'h0a00_0000_0300, 7, 6'h00);
      check("stp", r.drop, i == 1 || i == 2);
    end
    @(posedge sys_clk_i) stp_en <= 1'b0;
    // three sweeps run, removing dynamic entries only
    @(posedge sys_clk_i) age_en <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    #1 check("busy", age_busy, 1);
    repeat (25000) @(posedge sys_clk_i);
    @(posedge sys_clk_i) age_en <= 1'b0;
    look(A, 0, 1'b0, 3'd0);
    look(48'h0600_0000_0050, 0, 1'b1, 3'd4);
    look(48'h0a00_0000_0200, 1, 1'b1, 3'd0);
    @(posedge sys_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 check("rst", {req_ready, stat_ready, age_busy, res}, '0);
    @(posedge sys_clk_i) rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 check("rdy", {req_ready, stat_ready}, 2'b11);
    look(48'h0a00_0000_0200, 1, 1'b0, 3'd0);
    summarize();
  end
endmodule
